// [design/ale_evaluator.sv]
// alarm logic evaluator: limits, two gate levels, delays, actions and gathered images
// assumes measurement values and cycle_tick come from logic on clk_sys; ext_in are pins
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RQ1 - each output is a two-level combination of configurable gates of six types
// RQ2 - and needs every used input true; nand is true when one is false
// RQ3 - or needs one used input true; nor needs none true
// RQ4 - xor needs exactly one true; xnor needs all true or all false
// RQ5 - first-level gates take three inputs, second-level gates take four
// RQ6 - unused gate inputs take the neutral value of the gate type
// RQ7 - upper limit sets above on threshold and clears below off threshold
// RQ8 - upper limit reads zero until on is reached after enabling
// RQ9 - lower limit sets below on threshold and clears above off threshold
// RQ10 - equal thresholds make an upper limit without hysteresis
// RQ11 - an hour counter runs only while its limit state is one
// RQ12 - evaluate first level, second level, delays, actions, each in index order
// RQ13 - one evaluation per measurement cycle, never more than 25 ms apart
// RQ14 - fed-back states use the previous evaluation's value
// RQ15 - first-level gates see lower-indexed first-level results at once
// RQ16 - float image holds up to 60 selected values, two registers each
// RQ17 - integer image holds up to 20 scaled values at consecutive registers
// RQ18 - integer entries are measurement times scale factor, then made integer
// RQ19 - both images refresh after every measurement cycle together
// RQ20 - delayed states follow with switch-in and dropout delays
// RQ21 - latched actions stay on until a reset request arrives
// RQ22 - scaled values outside sixteen bits saturate instead of wrapping
module ale_evaluator #(
    parameter int NUM_MEAS = 64,
    parameter int FLT_N = ale_pkg::FLT_IMG_MAX,
    parameter int INT_N = ale_pkg::INT_IMG_MAX,
    parameter int WD_CYCLES = ale_pkg::EVAL_MAX_CYCLES,
    parameter int MS_CYCLES = ale_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // measurement engine
    input wire logic cycle_tick,
    input wire logic [NUM_MEAS-1:0][31:0] meas_float,
    input wire logic [NUM_MEAS-1:0][31:0] meas_fixed,
    // external conditions and reset command
    input wire logic [ale_pkg::NUM_EXT-1:0] ext_in,
    input wire logic alarm_reset_cmd,
    // limit configuration
    input wire logic [ale_pkg::NUM_LIM-1:0] lim_enable,
    input wire logic [ale_pkg::NUM_LIM-1:0][ale_pkg::MSEL_W-1:0] lim_meas_sel,
    input wire logic [ale_pkg::NUM_LIM-1:0][31:0] lim_on,
    input wire logic [ale_pkg::NUM_LIM-1:0][31:0] lim_off,
    // gate configuration
    input wire logic [3:0][2:0] l1_type,
    input wire logic [3:0][ale_pkg::L1_IN-1:0][ale_pkg::SEL_W-1:0] l1_sel,
    input wire logic [3:0][ale_pkg::L1_IN-1:0] l1_used,
    input wire logic [3:0][2:0] l2_type,
    input wire logic [3:0][ale_pkg::L2_IN-1:0][ale_pkg::SEL_W-1:0] l2_sel,
    input wire logic [3:0][ale_pkg::L2_IN-1:0] l2_used,
    // delay and action configuration
    input wire logic [3:0][ale_pkg::DLY_W-1:0] dly_on_ms,
    input wire logic [3:0][ale_pkg::DLY_W-1:0] dly_off_ms,
    input wire logic [3:0] act_latch,
    input wire logic [3:0] act_invert,
    input wire logic reset_src_used,
    input wire logic [ale_pkg::SEL_W-1:0] reset_src_sel,
    // hour counter and image configuration
    input wire logic [ale_pkg::NUM_OHC-1:0][2:0] ohc_sel,
    input wire logic [FLT_N-1:0][ale_pkg::MSEL_W-1:0] flt_sel,
    input wire logic [INT_N-1:0][ale_pkg::MSEL_W-1:0] int_sel,
    input wire logic [INT_N-1:0][15:0] int_scale,
    // register read port
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_err,
    // logic states
    output logic [ale_pkg::NUM_LIM-1:0] limit_states,
    output logic [3:0] first_level_outputs,
    output logic [3:0] second_level_outputs,
    output logic [3:0] delayed_states,
    output logic [3:0] action_outputs,
    output logic [3:0] relay_drive,
    output logic eval_done,
    output logic [ale_pkg::NUM_OHC-1:0][31:0] ohc_count
);

    localparam int WDW = ale_pkg::WD_W;
    localparam int MSW = ale_pkg::MS_W;
    localparam int NL = ale_pkg::NUM_LIM;
    localparam int NE = ale_pkg::NUM_EXT;
    localparam int SW = ale_pkg::SRC_W;

    // refuse sizes the counters, selectors or address map cannot hold
    if (NUM_MEAS < 1 || NUM_MEAS > 64) begin : g_bad_meas
        $error("NUM_MEAS must be 1 to 64");
    end
    if (FLT_N < 1 || FLT_N > ale_pkg::FLT_IMG_MAX) begin : g_bad_flt
        $error("FLT_N must be 1 to 60");
    end
    if (INT_N < 1 || INT_N > ale_pkg::INT_IMG_MAX) begin : g_bad_int
        $error("INT_N must be 1 to 20");
    end
    if (WD_CYCLES < 2 || WD_CYCLES >= 2 ** WDW) begin : g_bad_wd
        $error("WD_CYCLES out of range");
    end
    if (MS_CYCLES < 2 || MS_CYCLES >= 2 ** MSW) begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end

    typedef struct packed {
        ale_pkg::ale_step_t step;
        logic [1:0] idx;
        logic [NL-1:0] lim;
        logic [3:0] y;
        logic [3:0] z;
        logic [3:0] d;
        logic [3:0] a;
        logic [3:0] snap_z;
        logic [3:0] snap_d;
        logic [3:0] snap_a;
        logic [NE-1:0] s1;
        logic [NE-1:0] s2;
        logic [NE-1:0] s3;
        logic [NE-1:0] ext;
        logic rst_pend;
        logic [WDW-1:0] wd_cnt;
        logic [MSW-1:0] ms_cnt;
        logic [3:0][ale_pkg::DLY_W-1:0] dtm;
        logic [ale_pkg::NUM_OHC-1:0][31:0] ohc;
        logic [FLT_N-1:0][31:0] fimg;
        logic [INT_N-1:0][15:0] iimg;
        logic [15:0] rd_data;
        logic rd_valid;
        logic rd_err;
        logic eval_done;
    } ale_state_t;

    ale_state_t r;
    ale_state_t n;
    logic [SW-1:0] src;
    logic [3:0] l1_out;
    logic [3:0] l2_out;
    logic ms_tick;
    logic trig;
    logic rst_req;

    // pick one condition from the source vector, zero for codes past its end
    function automatic logic pick(input logic [SW-1:0] v, input logic [ale_pkg::SEL_W-1:0] s);
        pick = (int'(s) < SW) ? v[s] : 1'b0;
    endfunction

    // scale, truncate to integer and clamp to the signed 16-bit range
    function automatic logic [15:0] scale_sat(input logic [31:0] m, input logic [15:0] k);
        logic signed [47:0] p;
        logic signed [23:0] ip;
        p = $signed(m) * $signed(k); // RQ18
        ip = p[47:ale_pkg::PROD_SHIFT];
        if (ip > $signed(24'h007FFF)) begin
            scale_sat = 16'h7FFF; // RQ22
        end else if (ip < $signed(24'hFF8000)) begin
            scale_sat = 16'h8000; // RQ22
        end else begin
            scale_sat = ip[15:0];
        end
    endfunction

    // z, d and a come from the snapshot, so feedback lags one evaluation;
    // y is live, so lower-indexed results are fresh
    assign src = {r.snap_a, r.snap_d, r.snap_z, r.y, r.ext, r.lim}; // RQ14 RQ15
    assign ms_tick = (r.ms_cnt == MSW'(MS_CYCLES - 1));
    assign trig = cycle_tick | (int'(r.wd_cnt) >= WD_CYCLES - 1); // RQ13
    assign rst_req = r.rst_pend | (reset_src_used & pick(src, reset_src_sel));

    // all gates are evaluated in parallel; the sequencer stores one per cycle
    for (genvar g = 0; g < 4; g++) begin : g_gate
        logic [ale_pkg::L1_IN-1:0] v1;
        logic [ale_pkg::L2_IN-1:0] v2;
        for (genvar k = 0; k < ale_pkg::L1_IN; k++) begin : g_v1
            assign v1[k] = pick(src, l1_sel[g][k]); // RQ5
        end
        for (genvar k = 0; k < ale_pkg::L2_IN; k++) begin : g_v2
            assign v2[k] = pick(src, l2_sel[g][k]); // RQ5
        end
        ale_gate #(.N(ale_pkg::L1_IN)) u_l1 (
            .gate_type(l1_type[g]),
            .in_used(l1_used[g]),
            .in_val(v1),
            .gate_out(l1_out[g])
        );
        ale_gate #(.N(ale_pkg::L2_IN)) u_l2 (
            .gate_type(l2_type[g]),
            .in_used(l2_used[g]),
            .in_val(v2),
            .gate_out(l2_out[g])
        );
    end

    // next state of the whole block
    always_comb begin
        logic signed [31:0] lv;
        logic [15:0] off;
        logic [ale_pkg::DLY_W-1:0] need;
        lv = 32'sh0;
        off = 16'h0;
        need = '0;
        n = r;
        n.eval_done = 1'b0;

        // pin synchroniser: a change counts once stages two and three agree
        n.s1 = ext_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.ext = (r.s2 & r.s3) | (r.ext & (r.s2 | r.s3));

        // millisecond enable for delays and hour counters
        n.ms_cnt = ms_tick ? '0 : MSW'(r.ms_cnt + 1'b1);

        // set wins over the end-of-evaluation clear
        if (r.step == ale_pkg::ST_A && r.idx == 2'h3) begin
            n.rst_pend = 1'b0;
        end
        if (alarm_reset_cmd) begin
            n.rst_pend = 1'b1;
        end

        // delay timers run while d differs from z
        for (int i = 0; i < 4; i++) begin
            if (r.z[i] == r.d[i]) begin
                n.dtm[i] = '0;
            end else if (ms_tick && r.dtm[i] != '1) begin
                n.dtm[i] = r.dtm[i] + 1'b1; // RQ20
            end
        end

        // hour counters count ms while their limit is set
        for (int i = 0; i < ale_pkg::NUM_OHC; i++) begin
            if (ms_tick && r.lim[ohc_sel[i]]) begin
                n.ohc[i] = r.ohc[i] + 32'h1; // RQ11
            end
        end

        // both images are taken from the same measurement cycle
        if (cycle_tick) begin
            for (int i = 0; i < FLT_N; i++) begin
                n.fimg[i] = (int'(flt_sel[i]) < NUM_MEAS) ? meas_float[flt_sel[i]] : 32'h0; // RQ16 RQ19
            end
            for (int i = 0; i < INT_N; i++) begin
                n.iimg[i] = (int'(int_sel[i]) < NUM_MEAS) ?
                    scale_sat(meas_fixed[int_sel[i]], int_scale[i]) : 16'h0; // RQ17 RQ19
            end
        end

        // watchdog counts from the start of the last evaluation
        if (r.step == ale_pkg::ST_IDLE && trig) begin
            n.wd_cnt = '0;
        end else if (int'(r.wd_cnt) < WD_CYCLES - 1) begin
            n.wd_cnt = WDW'(r.wd_cnt + 1'b1);
        end

        // evaluation sequencer, one element per cycle
        case (r.step) // RQ12
            ale_pkg::ST_IDLE: begin
                if (trig) begin
                    for (int i = 0; i < NL; i++) begin
                        lv = (int'(lim_meas_sel[i]) < NUM_MEAS) ? meas_fixed[lim_meas_sel[i]] : 32'sh0;
                        if (!lim_enable[i]) begin
                            n.lim[i] = 1'b0; // RQ8
                        end else if ($signed(lim_on[i]) >= $signed(lim_off[i])) begin
                            // equal thresholds fall here: upper limit, no hysteresis
                            if (lv > $signed(lim_on[i])) begin
                                n.lim[i] = 1'b1; // RQ7 RQ10
                            end else if (lv < $signed(lim_off[i])) begin
                                n.lim[i] = 1'b0; // RQ7 RQ8
                            end
                        end else begin
                            if (lv < $signed(lim_on[i])) begin
                                n.lim[i] = 1'b1; // RQ9
                            end else if (lv > $signed(lim_off[i])) begin
                                n.lim[i] = 1'b0; // RQ9
                            end
                        end
                    end
                    n.snap_z = r.z; // RQ14
                    n.snap_d = r.d;
                    n.snap_a = r.a;
                    n.step = ale_pkg::ST_Y;
                    n.idx = 2'h0;
                end
            end
            ale_pkg::ST_Y: begin
                n.y[r.idx] = l1_out[r.idx]; // RQ15
                n.idx = r.idx + 2'h1;
                if (r.idx == 2'h3) begin
                    n.step = ale_pkg::ST_Z;
                end
            end
            ale_pkg::ST_Z: begin
                n.z[r.idx] = l2_out[r.idx];
                n.idx = r.idx + 2'h1;
                if (r.idx == 2'h3) begin
                    n.step = ale_pkg::ST_D;
                end
            end
            ale_pkg::ST_D: begin
                need = r.z[r.idx] ? dly_on_ms[r.idx] : dly_off_ms[r.idx];
                if (r.z[r.idx] != r.d[r.idx] && r.dtm[r.idx] >= need) begin
                    n.d[r.idx] = r.z[r.idx]; // RQ20
                end
                n.idx = r.idx + 2'h1;
                if (r.idx == 2'h3) begin
                    n.step = ale_pkg::ST_A;
                end
            end
            ale_pkg::ST_A: begin
                // a latched action survives the drop of its cause until reset
                n.a[r.idx] = r.d[r.idx] | (act_latch[r.idx] & r.a[r.idx] & ~rst_req); // RQ21
                n.idx = r.idx + 2'h1;
                if (r.idx == 2'h3) begin
                    n.step = ale_pkg::ST_IDLE;
                    n.eval_done = 1'b1;
                end
            end
            default: begin
                n.step = ale_pkg::ST_IDLE;
            end
        endcase

        // register read port, one cycle latency, unmapped reads return zero
        n.rd_valid = rd_en;
        if (rd_en) begin
            n.rd_err = 1'b0;
            n.rd_data = ale_pkg::RD_DATA_RST;
            if (rd_addr >= ale_pkg::INT_IMG_BASE && rd_addr < ale_pkg::INT_IMG_BASE + 16'(INT_N)) begin
                off = rd_addr - ale_pkg::INT_IMG_BASE;
                n.rd_data = r.iimg[off[4:0]]; // RQ17
            end else if (rd_addr >= ale_pkg::FLT_IMG_BASE &&
                         rd_addr < ale_pkg::FLT_IMG_BASE + 16'(FLT_N * ale_pkg::FLT_REGS_PER_VALUE)) begin
                off = rd_addr - ale_pkg::FLT_IMG_BASE;
                // high word at the even register, low word at the odd one
                n.rd_data = off[0] ? r.fimg[off[6:1]][15:0] : r.fimg[off[6:1]][31:16]; // RQ16
            end else begin
                n.rd_err = 1'b1;
            end
        end
    end

    // single state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign rd_err = r.rd_err;
    assign limit_states = r.lim;
    assign first_level_outputs = r.y;
    assign second_level_outputs = r.z;
    assign delayed_states = r.d;
    assign action_outputs = r.a;
    assign relay_drive = r.a ^ act_invert; // inversion is a wiring choice, not a state
    assign eval_done = r.eval_done;
    assign ohc_count = r.ohc;

    // checks on the sequencer, limits, actions and read port
    logic signed [31:0] lv0;
    assign lv0 = meas_fixed[lim_meas_sel[0]];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    eval_order_a: assert property ((r.step == ale_pkg::ST_Y && r.idx == 2'h3) |=> // RQ12
        (r.step == ale_pkg::ST_Z && r.idx == 2'h0)) else $error("first level not followed by second");
    eval_length_a: assert property ((r.step == ale_pkg::ST_Y && r.idx == 2'h0) |-> // RQ12
        ##15 (r.step == ale_pkg::ST_A && r.idx == 2'h3) ##1 r.eval_done) else $error("evaluation length wrong");
    watchdog_bound_a: assert property (int'(r.wd_cnt) < WD_CYCLES) else $error("evaluation gap too long"); // RQ13
    upper_on_a: assert property ((r.step == ale_pkg::ST_IDLE && trig && lim_enable[0] && // RQ7
        $signed(lim_on[0]) >= $signed(lim_off[0]) && lv0 > $signed(lim_on[0])) |=> r.lim[0])
        else $error("upper limit did not set");
    lower_on_a: assert property ((r.step == ale_pkg::ST_IDLE && trig && lim_enable[0] && // RQ9
        $signed(lim_on[0]) < $signed(lim_off[0]) && lv0 < $signed(lim_on[0])) |=> r.lim[0])
        else $error("lower limit did not set");
    limit_off_a: assert property ((r.step == ale_pkg::ST_IDLE && trig && !lim_enable[0]) |=> !r.lim[0]) // RQ8
        else $error("disabled limit not zero");
    snap_hold_a: assert property ((r.step != ale_pkg::ST_IDLE) |=> $stable(r.snap_z)) // RQ14
        else $error("feedback snapshot moved");
    same_eval_a: assert property ((r.step == ale_pkg::ST_Y && r.idx == 2'h1 && l1_type[1] == ale_pkg::GATE_OR && // RQ15
        l1_used[1] == 3'h1 && int'(l1_sel[1][0]) == ale_pkg::SRC_Y) |=> r.y[1] == $past(r.y[0]))
        else $error("first level chain delayed");
    unused_and_a: assert property ((r.step == ale_pkg::ST_Z && r.idx == 2'h0 && // RQ6
        l2_type[0] == ale_pkg::GATE_AND && l2_used[0] == 4'h0) |=> r.z[0]) else $error("unused input not neutral");
    delay_zero_a: assert property ((r.step == ale_pkg::ST_D && r.idx == 2'h0 && r.z[0] && !r.d[0] && // RQ20
        dly_on_ms[0] == 16'h0) |=> r.d[0]) else $error("zero delay did not pass");
    latch_hold_a: assert property ((r.step == ale_pkg::ST_A && r.idx == 2'h0 && act_latch[0] && r.a[0] && // RQ21
        !rst_req) |=> r.a[0]) else $error("latched action dropped");
    follow_a: assert property ((r.step == ale_pkg::ST_A && r.idx == 2'h0 && !act_latch[0]) |=> // RQ21
        r.a[0] == $past(r.d[0])) else $error("action not following delayed state");
    ohc_stop_a: assert property (!r.lim[ohc_sel[0]] |=> r.ohc[0] == $past(r.ohc[0])) // RQ11
        else $error("hour counter ran while limit clear");
    read_int_a: assert property ((rd_en && rd_addr == ale_pkg::INT_IMG_BASE) |=> // RQ17
        (r.rd_valid && !r.rd_err && r.rd_data == $past(r.iimg[0]))) else $error("integer image read wrong");

    eval_seen_c: cover property (r.eval_done);
    watchdog_c: cover property (r.step == ale_pkg::ST_IDLE && !cycle_tick && trig);
    latched_c: cover property (r.a[0] && !r.d[0] && act_latch[0]);
    saturate_c: cover property (r.iimg[0] == 16'h7FFF);

endmodule

`default_nettype wire

// [design/ale_gate.sv]
// one configurable logic gate with a per-input used mask
// assumes stable inputs from the caller; purely combinational
`timescale 1ns/1ps
`default_nettype none

module ale_gate #(
    parameter int N = 3
) (
    // configuration
    input wire logic [2:0] gate_type,
    input wire logic [N-1:0] in_used,
    // conditions
    input wire logic [N-1:0] in_val,
    // result
    output logic gate_out
);

    logic all_true;
    logic any_true;
    logic one_true;
    logic [3:0] ones;

    // the count of true inputs is four bits wide
    if (N < 1 || N > 15) begin : g_bad_n
        $error("N must be 1 to 15");
    end

    // unused inputs are masked to the neutral value of each reduction
    always_comb begin
        all_true = &(in_val | ~in_used); // RQ6
        any_true = |(in_val & in_used); // RQ6
        ones = 4'h0;
        for (int k = 0; k < N; k++) begin
            ones = ones + {3'h0, in_val[k] & in_used[k]};
        end
        one_true = (ones == 4'h1);
    end

    // the inverted types are the plain types negated, except xnor
    always_comb begin
        case (gate_type) // RQ1
            ale_pkg::GATE_AND: gate_out = all_true; // RQ2
            ale_pkg::GATE_NAND: gate_out = ~all_true; // RQ2
            ale_pkg::GATE_OR: gate_out = any_true; // RQ3
            ale_pkg::GATE_NOR: gate_out = ~any_true; // RQ3
            ale_pkg::GATE_XOR: gate_out = one_true; // RQ4
            ale_pkg::GATE_XNOR: gate_out = all_true | ~any_true; // RQ4
            default: gate_out = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// [design/ale_pkg.sv]
// constants and types shared by the alarm logic evaluator
// assumes a 100 MHz system clock and the register image addresses fixed below
package ale_pkg;

    // clock rate and evaluation timing
    localparam int CLK_HZ = 100_000_000;
    localparam int EVAL_MAX_MS = 25;
    localparam int EVAL_MAX_CYCLES = EVAL_MAX_MS * (CLK_HZ / 1000); // longest time, rounds down
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int WD_W = 22;
    localparam int MS_W = 17;

    // logic structure
    localparam int NUM_GATES = 4;
    localparam int L1_IN = 3;
    localparam int L2_IN = 4;
    localparam int NUM_LIM = 8;
    localparam int NUM_EXT = 4;
    localparam int NUM_OHC = 4;
    localparam int SEL_W = 5;
    localparam int MSEL_W = 6;
    localparam int DLY_W = 16;

    // position of each state group in the gate source vector
    localparam int SRC_LIM = 0;
    localparam int SRC_EXT = 8;
    localparam int SRC_Y = 12;
    localparam int SRC_Z = 16;
    localparam int SRC_D = 20;
    localparam int SRC_A = 24;
    localparam int SRC_W = 28;

    // gate type encodings
    localparam logic [2:0] GATE_AND = 3'h0;
    localparam logic [2:0] GATE_OR = 3'h1;
    localparam logic [2:0] GATE_XOR = 3'h2;
    localparam logic [2:0] GATE_NAND = 3'h3;
    localparam logic [2:0] GATE_NOR = 3'h4;
    localparam logic [2:0] GATE_XNOR = 3'h5;

    // gathered register images
    localparam logic [15:0] INT_IMG_BASE = 16'hA348;
    localparam logic [15:0] FLT_IMG_BASE = 16'hA370;
    localparam int INT_IMG_MAX = 20;
    localparam int FLT_IMG_MAX = 60;
    localparam int FLT_REGS_PER_VALUE = 2;
    localparam logic [15:0] RD_DATA_RST = 16'h0000;

    // fixed-point formats: measurement q16.16, scale factor q8.8
    localparam int MEAS_FRAC = 16;
    localparam int SCALE_FRAC = 8;
    localparam int PROD_SHIFT = MEAS_FRAC + SCALE_FRAC;

    // evaluation sequence states
    typedef enum logic [2:0] {ST_IDLE, ST_Y, ST_Z, ST_D, ST_A} ale_step_t;

endpackage

// [test/ale_evaluator_tb_top.sv]
// self-checking bench of the alarm logic evaluator
// assumes ticks every 40 clocks, beyond the 17-cycle evaluation
`timescale 1ns/1ps
`default_nettype none
module ale_evaluator_tb_top;
    logic clk_sys = '0;
    logic reset_n = '0;
    logic [31:0] level = '0;
    logic alarm_reset_cmd = '0, reset_src_used = '0, rd_en = '0;
    logic [3:0] ext_in = '0, act_latch = '0, act_invert = '0;
    logic [7:0] lim_enable = '0;
    logic [7:0][5:0] lim_meas_sel = '0;
    logic [7:0][31:0] lim_on = '0, lim_off = '0;
    logic [3:0][2:0] l1_type = '0, l2_type = '0, ohc_sel = '0, l1_used = '0;
    logic [3:0][2:0][4:0] l1_sel = '0;
    logic [3:0][3:0][4:0] l2_sel = '0;
    logic [3:0][3:0] l2_used = '0;
    logic [3:0][15:0] dly_on_ms = '0, dly_off_ms = '0;
    logic [4:0] reset_src_sel = '0;
    logic [59:0][5:0] flt_sel = '0;
    logic [19:0][5:0] int_sel = '0;
    logic [19:0][15:0] int_scale = '0;
    logic [15:0] rd_addr = '0, rd_data;
    logic cycle_tick, rd_valid, rd_err, eval_done;
    logic [63:0][31:0] meas_float, meas_fixed;
    logic [7:0] limit_states;
    logic [3:0] first_level_outputs, second_level_outputs, delayed_states, action_outputs, relay_drive;
    logic [3:0][31:0] ohc_count;
    int bad_count = 0, total_checks = 0;
    // short timings keep the run brief; every port connects to the signal of its own name
    ale_evaluator #(.WD_CYCLES(200), .MS_CYCLES(10)) u_dut (.*);
    ale_meas_model u_meas (.*);
    // clock
    initial forever #5 clk_sys = ~clk_sys;
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // gate result from the used inputs only, so unused ones must be neutral
    function automatic logic gexp(input int t, input logic [2:0] p, input logic [2:0] u);
        int c = $countones(p & u), n = $countones(u);
        logic [5:0] r = {c == n || c == 0, c == 0, c != n, c == 1, c > 0, c == n};
        return r[t];
    endfunction
    // bounded wait for the next eval_done, returns on a falling edge
    task automatic ev;
        int k;
        for (k = 0; k < 100; k++) begin
            @(posedge clk_sys);
            #1;
            if (eval_done === 1'b1) break;
        end
        if (k == 100) chk("eval_done", 16'h1, 16'h0);
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_en = 1'b0;
        chk("rd_valid", 16'h1, 16'(rd_valid));
        @(negedge clk_sys);
    endtask
    task automatic t_gates;
        logic e;
        logic p;
        l1_sel[0] = {5'h0A, 5'h09, 5'h08};
        l1_sel[1][0] = 5'h0C;
        l1_sel[2][0] = 5'h10;
        l1_used[1] = 3'h1;
        l1_used[2] = 3'h1;
        l2_sel[0][0] = 5'h0C;
        l2_used[0] = 4'h1;
        l2_type[0] = ale_pkg::GATE_OR;
        for (int t = 0; t < 6; t++) begin
            for (int m = 0; m < 16; m++) begin
                l1_type[0] = 3'(t);
                l1_used[0] = m[3] ? 3'h3 : 3'h7;
                ext_in = 4'(m);
                ev();
                e = gexp(t, m[2:0], l1_used[0]);
                chk("y1", 16'(e), 16'(first_level_outputs[0]));
                chk("y2", 16'(e), 16'(first_level_outputs[1]));
                if (t + m > 0) chk("y3", 16'(p), 16'(first_level_outputs[2]));
                chk("chain", 16'({3{e}}), 16'({second_level_outputs[0], delayed_states[0], action_outputs[0]}));
                p = e;
            end
        end
    endtask
    task automatic t_limits;
        logic [7:0] lv [4] = '{8'h04, 8'h06, 8'h04, 8'h02};
        logic [2:0] ex [4] = '{3'h0, 3'h5, 3'h5, 3'h2};
        chk("ohc", 16'h0, ohc_count[0][15:0]);
        lim_on[0] = 32'h0005_0000;
        lim_off[0] = 32'h0003_0000;
        lim_on[1] = 32'h0003_0000;
        lim_off[1] = 32'h0005_0000;
        lim_on[2] = 32'h0006_0000;
        lim_off[2] = 32'h0006_0000;
        lim_meas_sel[2] = 6'h02;
        lim_enable = 8'h07;
        for (int i = 0; i < 4; i++) begin
            level = {8'h00, lv[i], 16'h0000};
            ev();
            chk("limits", 16'(ex[i]), 16'(limit_states[2:0]));
        end
    endtask
    task automatic t_images;
        logic [15:0] ad [6] = '{16'hA348, 16'hA349, 16'hA34A, 16'hA370, 16'hA371, 16'hA360};
        logic [15:0] ex [6] = '{16'h1000, 16'h7FFF, 16'h8000, 16'hEFFF, 16'hFFFE, 16'h0000};
        int_scale[2:0] = {16'h8000, 16'h7FFF, 16'h0100};
        int_sel[2:0] = {6'h02, 6'h01, 6'h00};
        flt_sel[0] = 6'h01;
        level = 32'h1000_0000;
        ev();
        for (int i = 0; i < 6; i++) begin
            rd(ad[i]);
            chk("rd_data", ex[i], rd_data);
            chk("rd_err", 16'(i == 5), 16'(rd_err));
        end
    endtask
    task automatic t_latch;
        l1_type[0] = ale_pkg::GATE_OR;
        l1_used[0] = 3'h1;
        act_latch[0] = 1'b1;
        act_invert[0] = 1'b1;
        for (int i = 0; i < 3; i++) begin
            ext_in = 4'(i == 0);
            alarm_reset_cmd = (i == 2);
            @(negedge clk_sys);
            alarm_reset_cmd = 1'b0;
            ev();
            chk("a1", 16'(i < 2), 16'(action_outputs[0]));
            chk("relay", 16'(i == 2), 16'(relay_drive[0]));
        end
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        ev();
        t_gates();
        t_limits();
        t_images();
        t_latch();
        end_sim();
    end
    // watchdog far above the 42 us the tests need
    initial begin
        #200us;
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire

// [test/ale_meas_model.sv]
// measurement engine stand-in: periodic tick with one snapshot per tick
// assumes level changes between ticks; outputs move only with the tick
`timescale 1ns/1ps
`default_nettype none
module ale_meas_model #(
    parameter int PERIOD = 40
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // base value from the bench
    input wire logic [31:0] level,
    // towards the evaluator
    output logic cycle_tick,
    output logic [63:0][31:0] meas_fixed,
    output logic [63:0][31:0] meas_float
);
    int cnt;
    // tick and values launch together off the falling edge
    always @(negedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            cycle_tick <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            cycle_tick <= (cnt == 0);
            for (int i = 0; i < 64; i++) begin
                if (cnt == 0) meas_fixed[i] <= level + 32'(i << 16);
                if (cnt == 0) meas_float[i] <= ~level ^ 32'(i);
            end
        end
    end
endmodule
`default_nettype wire
